// >>> rtl/genlock_control_offset_regs.sv
// Genlock control, pulse reset control and timing offset registers.
// Assumes lock terms and frame/field marks come from logic on core_clk_i.
`timescale 1ns/1ns
`default_nettype none
module genlock_control_offset_regs #(
  parameter bit HAS_AUDIO = 1'b1
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Host register port
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [genlock_regs_pkg::ADDR_W-1:0] host_addr_i,
  input wire logic [genlock_regs_pkg::DATA_W-1:0] host_wdata_i,
  output logic [genlock_regs_pkg::DATA_W-1:0] host_rdata_o,
  // External genlock pin
  input wire logic genlock_pin_i,
  // Lock terms and output timing marks
  input wire genlock_regs_pkg::lock_terms_t lock_terms_i,
  input wire logic field_start_i,
  input wire logic frame_start_i,
  // Control outputs
  output logic genlock_cmd_o,
  output logic drift_lock_o,
  output logic extended_audio_o,
  output logic reference_lock_o,
  output logic audio_frame_sync_pulse_reset_o,
  output logic ten_field_identification_pulse_reset_o,
  output genlock_regs_pkg::delay_pair_t offset_o
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  localparam logic [genlock_regs_pkg::DATA_W-1:0] PULSE_MASK =
    HAS_AUDIO ? genlock_regs_pkg::PULSE_RESET_MASK_AUDIO
              : genlock_regs_pkg::PULSE_RESET_MASK_NO_AUDIO;

  genlock_regs_pkg::lock_control_t lock_control;
  genlock_regs_pkg::pulse_reset_control_t pulse_reset_control;
  logic [genlock_regs_pkg::DATA_W-1:0] horizontal_delay_value;
  logic [genlock_regs_pkg::DATA_W-1:0] vertical_delay_value;
  genlock_regs_pkg::lock_control_t next_lock_control;
  genlock_regs_pkg::pulse_reset_control_t next_pulse_reset_control;
  logic [genlock_regs_pkg::DATA_W-1:0] next_horizontal_delay_value;
  logic [genlock_regs_pkg::DATA_W-1:0] next_vertical_delay_value;
  logic [genlock_regs_pkg::DATA_W-1:0] next_host_rdata;
  logic wr_lock;
  logic wr_pulse;

  // ----------------------------------------------------------------
  // Host writes and reads
  // ----------------------------------------------------------------
  always_comb begin
    wr_lock = host_wr_i &&
              host_addr_i == genlock_regs_pkg::LOCK_CONTROL_ADDR;
    wr_pulse = host_wr_i &&
               host_addr_i == genlock_regs_pkg::PULSE_RESET_CONTROL_ADDR;
    next_lock_control = lock_control;
    next_pulse_reset_control = pulse_reset_control;
    next_horizontal_delay_value = horizontal_delay_value;
    next_vertical_delay_value = vertical_delay_value;
    next_host_rdata = host_rdata_o;
    if (wr_lock) begin
      // Reserved bits are dropped so they always read zero
      next_lock_control = host_wdata_i &
                          genlock_regs_pkg::LOCK_CONTROL_MASK;
    end
    if (wr_pulse) begin
      // Audio enable held low on the variant without audio
      next_pulse_reset_control = host_wdata_i & PULSE_MASK;
    end
    if (host_wr_i &&
        host_addr_i == genlock_regs_pkg::HORIZONTAL_DELAY_VALUE_ADDR) begin
      next_horizontal_delay_value = host_wdata_i;
    end
    if (host_wr_i &&
        host_addr_i == genlock_regs_pkg::VERTICAL_DELAY_VALUE_ADDR) begin
      next_vertical_delay_value = host_wdata_i;
    end
    if (host_rd_i) begin
      case (host_addr_i)
        genlock_regs_pkg::LOCK_CONTROL_ADDR: begin
          next_host_rdata = lock_control;
        end
        genlock_regs_pkg::PULSE_RESET_CONTROL_ADDR: begin
          next_host_rdata = pulse_reset_control;
        end
        genlock_regs_pkg::HORIZONTAL_DELAY_VALUE_ADDR: begin
          next_host_rdata = horizontal_delay_value;
        end
        genlock_regs_pkg::VERTICAL_DELAY_VALUE_ADDR: begin
          next_host_rdata = vertical_delay_value;
        end
        default: begin
          next_host_rdata = genlock_regs_pkg::REG_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_control <= genlock_regs_pkg::REG_RESET;
      pulse_reset_control <= genlock_regs_pkg::REG_RESET;
      horizontal_delay_value <= genlock_regs_pkg::REG_RESET;
      vertical_delay_value <= genlock_regs_pkg::REG_RESET;
      host_rdata_o <= genlock_regs_pkg::REG_RESET;
    end else if (ce_i) begin
      lock_control <= next_lock_control;
      pulse_reset_control <= next_pulse_reset_control;
      horizontal_delay_value <= next_horizontal_delay_value;
      vertical_delay_value <= next_vertical_delay_value;
      host_rdata_o <= next_host_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Genlock command, lock mode and reference lock
  // ----------------------------------------------------------------
  logic pin_level;
  logic next_genlock_cmd;
  logic next_reference_lock;

  pin_level_sync genlock_pin_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(genlock_pin_i),
    .level_o(pin_level)
  );

  always_comb begin
    next_genlock_cmd = lock_control.genlock_from_host ?
                       lock_control.genlock_request : pin_level;
    next_reference_lock = lock_terms_i.clock_lock &&
      (lock_terms_i.horizontal_lock ||
       lock_control.horizontal_lock_mask) &&
      (lock_terms_i.vertical_lock ||
       lock_control.vertical_lock_mask) &&
      (lock_terms_i.field_lock || lock_control.field_lock_mask);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      genlock_cmd_o <= 1'b0;
      drift_lock_o <= 1'b0;
      extended_audio_o <= 1'b0;
      reference_lock_o <= 1'b0;
    end else if (ce_i) begin
      genlock_cmd_o <= next_genlock_cmd;
      drift_lock_o <= lock_control.drift_lock;
      extended_audio_o <= lock_control.extended_audio;
      reference_lock_o <= next_reference_lock;
    end
  end

  // ----------------------------------------------------------------
  // Strobe-driven pulse resets
  // ----------------------------------------------------------------
  // Own sequencer, untouched by reference-derived resets
  genlock_regs_pkg::strobe_state_t strobe_state;
  genlock_regs_pkg::strobe_state_t next_strobe_state;
  genlock_regs_pkg::pulse_reset_control_t pulse_wdata;
  logic next_audio_frame_pulse_reset_enable;
  logic next_tfid_reset;

  always_comb begin
    pulse_wdata = host_wdata_i;
    next_strobe_state = strobe_state;
    next_audio_frame_pulse_reset_enable = 1'b0;
    next_tfid_reset = 1'b0;
    case (strobe_state)
      genlock_regs_pkg::STROBE_IDLE: begin
        if (wr_pulse && pulse_wdata.reset_strobe) begin
          next_strobe_state = genlock_regs_pkg::STROBE_HIGH;
        end
      end
      genlock_regs_pkg::STROBE_HIGH: begin
        // A strobe must complete within one output frame
        if (frame_start_i) begin
          next_strobe_state = genlock_regs_pkg::STROBE_IDLE;
        end else if (wr_pulse && !pulse_wdata.reset_strobe) begin
          next_strobe_state = genlock_regs_pkg::STROBE_ARMED;
        end
      end
      genlock_regs_pkg::STROBE_ARMED: begin
        if (frame_start_i) begin
          next_strobe_state = genlock_regs_pkg::STROBE_IDLE;
          next_audio_frame_pulse_reset_enable =
            pulse_reset_control.audio_frame_pulse_reset_enable;
          next_tfid_reset =
            pulse_reset_control.ten_field_pulse_reset_enable;
        end
      end
      default: begin
        next_strobe_state = genlock_regs_pkg::STROBE_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strobe_state <= genlock_regs_pkg::STROBE_IDLE;
      audio_frame_sync_pulse_reset_o <= 1'b0;
      ten_field_identification_pulse_reset_o <= 1'b0;
    end else if (ce_i) begin
      strobe_state <= next_strobe_state;
      audio_frame_sync_pulse_reset_o <= next_audio_frame_pulse_reset_enable;
      ten_field_identification_pulse_reset_o <= next_tfid_reset;
    end
  end

  // ----------------------------------------------------------------
  // Offsets forwarded once per field
  // ----------------------------------------------------------------
  genlock_regs_pkg::delay_pair_t next_offset;

  always_comb begin
    next_offset = offset_o;
    if (field_start_i) begin
      next_offset.horizontal = horizontal_delay_value;
      next_offset.vertical = vertical_delay_value;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      offset_o <= '0;
    end else if (ce_i) begin
      offset_o <= next_offset;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ref_lock_terms_a:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i |=> reference_lock_o == ($past(lock_terms_i.clock_lock) &&
      ($past(lock_terms_i.horizontal_lock) ||
       $past(lock_control.horizontal_lock_mask)) &&
      ($past(lock_terms_i.vertical_lock) ||
       $past(lock_control.vertical_lock_mask)) &&
      ($past(lock_terms_i.field_lock) ||
       $past(lock_control.field_lock_mask))))
    else $error("reference lock does not match unmasked terms");

  host_genlock_a:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && lock_control.genlock_from_host |=>
      genlock_cmd_o == $past(lock_control.genlock_request))
    else $error("genlock command not taken from register");

  pin_genlock_a:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && !lock_control.genlock_from_host |=>
      genlock_cmd_o == $past(pin_level))
    else $error("genlock command not taken from pin");

  lock_mode_a:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && wr_lock ##1 ce_i |=> drift_lock_o == $past(host_wdata_i[1], 2))
    else $error("drift mode does not follow register write");

  audio_mode_a:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && wr_lock ##1 ce_i |=>
      extended_audio_o == $past(host_wdata_i[6], 2))
    else $error("extended audio mode does not follow register write");

  offset_hold_a:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(ce_i && field_start_i) |=> $stable(offset_o))
    else $error("offset changed away from a field boundary");

  offset_take_a:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && field_start_i |=>
      offset_o.horizontal == $past(horizontal_delay_value) &&
      offset_o.vertical == $past(vertical_delay_value))
    else $error("offset not sampled at field boundary");

  strobe_reset_a:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(audio_frame_sync_pulse_reset_o) ||
    $rose(ten_field_identification_pulse_reset_o) |->
      $past(frame_start_i) &&
      $past(strobe_state) == genlock_regs_pkg::STROBE_ARMED)
    else $error("pulse reset outside armed frame start");

  no_audio_bit_a:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    !HAS_AUDIO |-> !pulse_reset_control.audio_frame_pulse_reset_enable)
    else $error("audio reset enable set on variant without audio");

endmodule : genlock_control_offset_regs
`default_nettype wire

// >>> shared/genlock_regs_pkg.sv
// Constants and field layouts for the genlock control and offset registers.
// Assumes a 16-bit host register port with 8-bit word addresses.
package genlock_regs_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] LOCK_CONTROL_ADDR = 8'h16;
  localparam logic [ADDR_W-1:0] PULSE_RESET_CONTROL_ADDR = 8'h1A;
  localparam logic [ADDR_W-1:0] HORIZONTAL_DELAY_VALUE_ADDR = 8'h1B;
  localparam logic [ADDR_W-1:0] VERTICAL_DELAY_VALUE_ADDR = 8'h1C;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0] reserved;
    logic extended_audio;
    logic genlock_from_host;
    logic field_lock_mask;
    logic vertical_lock_mask;
    logic horizontal_lock_mask;
    logic drift_lock;
    logic genlock_request;
  } lock_control_t;

  typedef struct packed {
    logic [11:0] reserved_hi;
    logic audio_frame_pulse_reset_enable;
    logic ten_field_pulse_reset_enable;
    logic reserved_lo;
    logic reset_strobe;
  } pulse_reset_control_t;

  typedef struct packed {
    logic clock_lock;
    logic horizontal_lock;
    logic vertical_lock;
    logic field_lock;
  } lock_terms_t;

  typedef struct packed {
    logic [DATA_W-1:0] horizontal;
    logic [DATA_W-1:0] vertical;
  } delay_pair_t;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] LOCK_CONTROL_MASK = 16'h007F;
  localparam logic [DATA_W-1:0] PULSE_RESET_MASK_AUDIO = 16'h000D;
  localparam logic [DATA_W-1:0] PULSE_RESET_MASK_NO_AUDIO = 16'h0005;

  typedef enum logic [1:0] {
    STROBE_IDLE,
    STROBE_HIGH,
    STROBE_ARMED
  } strobe_state_t;

endpackage : genlock_regs_pkg

// >>> rtl/pin_level_sync.sv
// Three-stage synchroniser for an asynchronous pin level.
// Assumes a free-running core clock; output follows once stages 2 and 3 agree.
`timescale 1ns/1ns
`default_nettype none
module pin_level_sync (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Pin and synchronised level
  input wire logic pin_i,
  output logic level_o
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic next_level;

  always_comb begin
    next_level = level_o;
    if (stage2 == stage3) begin
      next_level = stage3;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level_o <= 1'b0;
    end else if (ce_i) begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
      level_o <= next_level;
    end
  end

endmodule : pin_level_sync
`default_nettype wire

// >>> test/ref_timing_model.sv
// Reference timing source: output field and frame boundary marks.
// Assumes the bench clock; marks change on its falling edge.
`timescale 1ns/1ns
`default_nettype none
module ref_timing_model #(
  parameter int FIELD_LEN = 16
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Output timing marks
  output logic field_start_o,
  output logic frame_start_o
);
  int cnt;
  logic odd;

  // ------------------------------------------------------------
  // One-cycle marks, a frame on every second field
  // ------------------------------------------------------------
  always @(negedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 0;
      odd <= 1'b0;
      field_start_o <= 1'b0;
      frame_start_o <= 1'b0;
    end else begin
      cnt <= (cnt == FIELD_LEN - 1) ? 0 : cnt + 1;
      field_start_o <= (cnt == FIELD_LEN - 1);
      frame_start_o <= (cnt == FIELD_LEN - 1) && odd;
      if (cnt == FIELD_LEN - 1) begin
        odd <= ~odd;
      end
    end
  end
endmodule : ref_timing_model
`default_nettype wire

// >>> test/tb_genlock_control_offset_regs.sv
// Self-checking bench for the genlock control and offset registers.
// Assumes the design checks its own timing relations with assertions.
`timescale 1ns/1ns
`default_nettype none
module tb_genlock_control_offset_regs;
  typedef struct packed {
    logic [1:0] kind;
    logic [31:0] val;
  } note_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic probe = 1'b0;
  logic pin = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  genlock_regs_pkg::lock_terms_t terms = 4'h0;
  genlock_regs_pkg::delay_pair_t offset;
  logic [15:0] rdata, rdata_na;
  // Output line and frame limits the host keeps to, plain defaults
  localparam logic [15:0] LINE_CLOCKS = 16'h0800;
  localparam logic [15:0] FRAME_LINES = 16'h0400;
  logic field_start, frame_start, cmd, drift, ext_audio, ref_lock;
  logic afs_rst, tfid_rst;
  note_t notes[$];
  int error_cnt = 0;
  int checks_done = 0;

  always #4 core_clk = ~core_clk;

  genlock_control_offset_regs #(
    .HAS_AUDIO(1'b1)
  ) i_genlock_control_offset_regs (
    .core_clk_i(core_clk),
    .rst_i(rst),
    .ce_i(ce),
    .host_wr_i(wr),
    .host_rd_i(rd),
    .host_addr_i(addr),
    .host_wdata_i(wdata),
    .host_rdata_o(rdata),
    .genlock_pin_i(pin),
    .lock_terms_i(terms),
    .field_start_i(field_start),
    .frame_start_i(frame_start),
    .genlock_cmd_o(cmd),
    .drift_lock_o(drift),
    .extended_audio_o(ext_audio),
    .reference_lock_o(ref_lock),
    .audio_frame_sync_pulse_reset_o(afs_rst),
    .ten_field_identification_pulse_reset_o(tfid_rst),
    .offset_o(offset)
  );

  // Variant without audio on the same host port
  if (1'b1) begin : no_audio_variant
    genlock_control_offset_regs #(
      .HAS_AUDIO(1'b0)
    ) i_genlock_control_offset_regs (
      .core_clk_i(core_clk),
      .rst_i(rst),
      .ce_i(ce),
      .host_wr_i(wr),
      .host_rd_i(rd),
      .host_addr_i(addr),
      .host_wdata_i(wdata),
      .host_rdata_o(rdata_na),
      .genlock_pin_i(pin),
      .lock_terms_i(terms),
      .field_start_i(field_start),
      .frame_start_i(frame_start),
      .genlock_cmd_o(),
      .drift_lock_o(),
      .extended_audio_o(),
      .reference_lock_o(),
      .audio_frame_sync_pulse_reset_o(),
      .ten_field_identification_pulse_reset_o(),
      .offset_o()
    );
  end

  ref_timing_model #(.FIELD_LEN(16)) i_ref_timing_model (
    .core_clk_i(core_clk),
    .rst_i(rst),
    .field_start_o(field_start),
    .frame_start_o(frame_start)
  );

  // ------------------------------------------------------------
  // Host tasks and expectation notes
  // ------------------------------------------------------------
  task automatic put(input logic [1:0] kind, input logic [31:0] val);
    notes.push_back({kind, val});
  endtask : put

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge core_clk);
    wr = 1'b0;
    @(negedge core_clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    rd = 1'b1;
    addr = a;
    put(2'h0, {(a == genlock_regs_pkg::PULSE_RESET_CONTROL_ADDR) ?
      e & 16'hFFF7 : e, e});
    @(negedge core_clk);
    rd = 1'b0;
    @(negedge core_clk);
  endtask : rd_reg

  task automatic look(input logic [1:0] kind, input logic [31:0] e);
    probe = 1'b1;
    put(kind, e);
    @(negedge core_clk);
    probe = 1'b0;
    @(negedge core_clk);
  endtask : look

  task automatic wait_mark(input bit frame);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (!(frame ? frame_start : field_start) && n < 100);
  endtask : wait_mark

  function automatic logic lock_exp(input logic [6:0] c);
    lock_exp = terms.clock_lock & (terms.horizontal_lock | c[2]) &
      (terms.vertical_lock | c[3]) & (terms.field_lock | c[4]);
  endfunction : lock_exp

  // ------------------------------------------------------------
  // Output watcher
  // ------------------------------------------------------------
  function automatic logic [31:0] seen(input logic [1:0] kind);
    case (kind)
      2'h0: seen = {rdata_na, rdata};
      2'h1: seen = {30'h0, afs_rst, tfid_rst};
      2'h2: seen = {28'h0, cmd, drift, ext_audio, ref_lock};
      default: seen = offset;
    endcase
  endfunction : seen

  task automatic take(input string what);
    note_t n;
    checks_done++;
    if (notes.size() == 0) begin
      error_cnt++;
      $display("CHECK FAILED %s expected none seen %h", what, seen(2'h1));
    end else begin
      n = notes.pop_front();
      if (seen(n.kind) !== n.val) begin
        error_cnt++;
        $display("CHECK FAILED %s expected %h seen %h", what, n.val,
          seen(n.kind));
      end
    end
  endtask : take

  always @(posedge core_clk) begin
    #2;
    if (rd === 1'b1) take("read data");
    if ((afs_rst | tfid_rst) !== 1'b0) take("pulse resets");
    if (probe === 1'b1) take("control outputs");
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    complete_run();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    logic [15:0] h, v;
    logic [6:0] c;
    logic [31:0] e;
    logic [31:0] old;
    old = 32'h0;
    void'($urandom(32'h7E93));
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    rd_reg(genlock_regs_pkg::LOCK_CONTROL_ADDR, 16'h0000);
    rd_reg(genlock_regs_pkg::PULSE_RESET_CONTROL_ADDR, 16'h0000);
    rd_reg(genlock_regs_pkg::HORIZONTAL_DELAY_VALUE_ADDR, 16'h0000);
    rd_reg(genlock_regs_pkg::VERTICAL_DELAY_VALUE_ADDR, 16'h0000);
    look(2'h2, 32'h0);
    look(2'h3, 32'h0);
    for (int i = 0; i < 24; i++) begin
      c = 7'($urandom);
      terms = 4'($urandom);
      pin = 1'($urandom);
      wr_reg(genlock_regs_pkg::LOCK_CONTROL_ADDR, {9'h000, c});
      repeat (6) @(negedge core_clk);
      e = {28'h0, c[5] ? c[0] : pin, c[1], c[6], lock_exp(c)};
      look(2'h2, e);
      rd_reg(genlock_regs_pkg::LOCK_CONTROL_ADDR, {9'h000, c});
    end
    // Reserved bits, unmapped place, frozen clock enable
    wr_reg(genlock_regs_pkg::LOCK_CONTROL_ADDR, 16'hFFFF);
    rd_reg(genlock_regs_pkg::LOCK_CONTROL_ADDR, 16'h007F);
    wr_reg(genlock_regs_pkg::PULSE_RESET_CONTROL_ADDR, 16'hFFF2);
    rd_reg(genlock_regs_pkg::PULSE_RESET_CONTROL_ADDR, 16'h0000);
    wr_reg(8'h17, 16'h1234);
    rd_reg(8'h17, 16'h0000);
    ce = 1'b0;
    wr_reg(genlock_regs_pkg::HORIZONTAL_DELAY_VALUE_ADDR, 16'hBEEF);
    ce = 1'b1;
    rd_reg(genlock_regs_pkg::HORIZONTAL_DELAY_VALUE_ADDR, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      h = 16'($urandom_range(LINE_CLOCKS));
      v = 16'($urandom_range(FRAME_LINES));
      wait_mark(1'b0);
      wr_reg(genlock_regs_pkg::HORIZONTAL_DELAY_VALUE_ADDR, h);
      wr_reg(genlock_regs_pkg::VERTICAL_DELAY_VALUE_ADDR, v);
      look(2'h3, old);
      wait_mark(1'b0);
      @(negedge core_clk);
      look(2'h3, {h, v});
      rd_reg(genlock_regs_pkg::VERTICAL_DELAY_VALUE_ADDR, v);
      old = {h, v};
    end
    for (int i = 1; i < 4; i++) begin
      wait_mark(1'b1);
      wr_reg(genlock_regs_pkg::PULSE_RESET_CONTROL_ADDR,
        {12'h000, 2'(i), 2'h1});
      wr_reg(genlock_regs_pkg::PULSE_RESET_CONTROL_ADDR,
        {12'h000, 2'(i), 2'h0});
      rd_reg(genlock_regs_pkg::PULSE_RESET_CONTROL_ADDR,
        {12'h000, 2'(i), 2'h0});
      put(2'h1, 32'(i));
    end
    // Strobe held across a frame boundary gives no pulse
    wait_mark(1'b1);
    wr_reg(genlock_regs_pkg::PULSE_RESET_CONTROL_ADDR, 16'h0005);
    wait_mark(1'b1);
    wr_reg(genlock_regs_pkg::PULSE_RESET_CONTROL_ADDR, 16'h0004);
    wait_mark(1'b1);
    repeat (4) @(negedge core_clk);
    if (notes.size() != 0) begin
      error_cnt++;
      $display("CHECK FAILED pending notes expected 0 seen %0d", notes.size());
    end
    complete_run();
  end
endmodule : tb_genlock_control_offset_regs
`default_nettype wire
